// *** core/ewp_pkg.sv ***
// Contract
// - host keeps write guard high throughout every read and program access.
// - host never drives control pulses narrower than 20ns unless intended.
// - host holds write guard low from its own reset, across power ramps.
// - host keeps guard high at least 10 ms after the last data byte.
// - in protect mode host sends the three-byte prefix before every write.
// - six ordered writes cancel protection; device returns to normal writing.
// - next byte within 30us; 100us idle strobes start internal programming.
package ewp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 22;
  localparam int STEP_W = 3;
  localparam int SYNC_STAGES = 2;

  typedef logic [ADDR_W-1:0] ewp_addr_t;
  typedef logic [DATA_W-1:0] ewp_data_t;
  typedef logic [CNT_W-1:0]  ewp_cnt_t;
  typedef logic [STEP_W-1:0] ewp_step_t;

  ////////////////////////////////////////////////////////////////////////////
  // timing, in printed units, and derived cycle counts
  localparam int CLK_NS     = 4;
  localparam int GLITCH_NS  = 20;
  localparam int STB_NS     = 250;
  localparam int ACC_NS     = 200;
  localparam int BL_MAX_US  = 30;
  localparam int WC_MS      = 10;
  localparam int RP_US      = 100;
  localparam int STB_CYC    = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC    = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC     = ACC_CYC + SYNC_STAGES + 1;
  localparam int BL_MAX_CYC = (BL_MAX_US * 1000) / CLK_NS;
  localparam int WC_CYC_DEF = (WC_MS * 1000000) / CLK_NS;
  localparam int RP_CYC_DEF = (RP_US * 1000) / CLK_NS;
  localparam int SETUP_CYC  = 2;
  localparam int HOLD_CYC   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // command words
  localparam ewp_addr_t CMD_ADDR_A = 17'h05555;
  localparam ewp_addr_t CMD_ADDR_B = 17'h02aaa;
  localparam ewp_data_t CMD_AA     = 8'haa;
  localparam ewp_data_t CMD_55     = 8'h55;
  localparam ewp_data_t CMD_A0     = 8'ha0;
  localparam ewp_data_t CMD_80     = 8'h80;
  localparam ewp_data_t CMD_20     = 8'h20;
  localparam ewp_step_t PREFIX_LEN = 3'h3;
  localparam ewp_step_t CANCEL_LEN = 3'h6;

  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_WRITE  = 2'h1,
    OP_WR_PROT = 2'h2,
    OP_UNPROT = 2'h3
  } ewp_op_t;

  typedef struct packed {
    ewp_op_t   op;
    ewp_addr_t addr;
    ewp_data_t data;
  } ewp_cmd_t;

  typedef struct packed {
    logic      ce_n;
    logic      oe_n;
    logic      we_n;
    logic      write_guard_n;
    ewp_addr_t addr;
    ewp_data_t dq;
    logic      dq_oe;
  } ewp_pins_t;

  typedef enum logic [2:0] {
    S_INIT  = 3'h0,
    S_IDLE  = 3'h1,
    S_SETUP = 3'h2,
    S_STB   = 3'h3,
    S_HOLD  = 3'h4,
    S_RD    = 3'h5,
    S_WC    = 3'h6
  } ewp_state_t;

endpackage : ewp_pkg

// *** core/ewp_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module ewp_host
  import ewp_pkg::*;
#(
  parameter int WC_CYC = WC_CYC_DEF,
  parameter int RP_CYC = RP_CYC_DEF
) (
  // clock, reset, enable
  input  wire logic      core_clk_in,
  input  wire logic      rst_in,
  input  wire logic      en_in,
  // user command side
  input  wire logic      cmd_valid_in,
  input  wire ewp_cmd_t  cmd_in,
  output logic           cmd_ready_out,
  output ewp_data_t      rd_data_out,
  output logic           rd_valid_out,
  output logic           prot_out,
  // device pins
  input  wire ewp_data_t dq_in,
  output ewp_pins_t      pins_out
);

  ////////////////////////////////////////////////////////////////////////////
  // word for step idx of the current transfer
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
    input ewp_op_t   op,
    input logic      pre,
    input ewp_step_t idx,
    input ewp_addr_t ua,
    input ewp_data_t ud
  );
    logic [ADDR_W+DATA_W-1:0] w;
    w = {ua, ud};
    if (op == OP_UNPROT) begin
      unique case (idx)
        3'h0:    w = {CMD_ADDR_A, CMD_AA};
        3'h1:    w = {CMD_ADDR_B, CMD_55};
        3'h2:    w = {CMD_ADDR_A, CMD_80};
        3'h3:    w = {CMD_ADDR_A, CMD_AA};
        3'h4:    w = {CMD_ADDR_B, CMD_55};
        default: w = {CMD_ADDR_A, CMD_20};
      endcase
    end else if (pre && idx < PREFIX_LEN) begin
      unique case (idx)
        3'h0:    w = {CMD_ADDR_A, CMD_AA};
        3'h1:    w = {CMD_ADDR_B, CMD_55};
        default: w = {CMD_ADDR_A, CMD_A0};
      endcase
    end
    return w;
  endfunction : seq_word

  ////////////////////////////////////////////////////////////////////////////
  ewp_state_t state_q;
  ewp_cnt_t   cnt_q;
  ewp_step_t  step_q;
  ewp_step_t  last_q;
  ewp_cmd_t   cmd_q;
  logic       pre_q;
  logic       prot_q;
  ewp_pins_t  pins_q;
  ewp_data_t  rd_q;
  logic       rdv_q;
  ewp_data_t  dq_s1_q;
  ewp_data_t  dq_s2_q;
  logic       tick;
  logic       take;
  logic       more;
  logic       use_pre;
  logic [ADDR_W+DATA_W-1:0] first_w;
  logic [ADDR_W+DATA_W-1:0] next_w;

  assign tick    = (cnt_q == '0);
  assign take    = (state_q == S_IDLE) && cmd_valid_in;
  assign more    = (step_q != last_q);
  // prefix goes out ahead of a write or protected write whenever protection is on or being armed; reads and cancel never get it
  assign use_pre = prot_q || (cmd_in.op == OP_WR_PROT);
  assign first_w = seq_word(cmd_in.op, use_pre, '0, cmd_in.addr, cmd_in.data);
  assign next_w  = seq_word(cmd_q.op, pre_q, step_q + 3'h1,
                            cmd_q.addr, cmd_q.data);

  assign cmd_ready_out = (state_q == S_IDLE);
  assign rd_data_out   = rd_q;
  assign rd_valid_out  = rdv_q;
  assign prot_out      = prot_q;
  assign pins_out      = pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // data pins arrive asynchronously
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else if (en_in) begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_INIT;
      cnt_q   <= ewp_cnt_t'(RP_CYC - 1);
      step_q  <= '0;
      last_q  <= '0;
      cmd_q   <= '0;
      pre_q   <= 1'b0;
    end else if (en_in) begin
      if (!tick && state_q != S_IDLE) begin
        cnt_q <= cnt_q - ewp_cnt_t'(1);
      end else begin
        unique case (state_q)
          S_INIT: state_q <= S_IDLE;
          S_IDLE: begin
            if (cmd_valid_in) begin
              cmd_q  <= cmd_in;
              pre_q  <= use_pre;
              step_q <= '0;
              if (cmd_in.op == OP_READ) begin
                state_q <= S_RD;
                cnt_q   <= ewp_cnt_t'(RD_CYC - 1);
              end else begin
                state_q <= S_SETUP;
                cnt_q   <= ewp_cnt_t'(SETUP_CYC - 1);
              end
              if (cmd_in.op == OP_UNPROT) begin
                last_q <= CANCEL_LEN - 3'h1;
              end else if (use_pre) begin
                last_q <= PREFIX_LEN;
              end else begin
                last_q <= '0;
              end
            end
          end
          S_SETUP: begin
            state_q <= S_STB;
            cnt_q   <= ewp_cnt_t'(STB_CYC - 1);
          end
          S_STB: begin
            state_q <= S_HOLD;
            cnt_q   <= ewp_cnt_t'(HOLD_CYC - 1);
          end
          S_HOLD: begin
            if (more) begin
              // next byte follows at once, well inside the load window
              step_q  <= step_q + 3'h1;
              state_q <= S_SETUP;
              cnt_q   <= ewp_cnt_t'(SETUP_CYC - 1);
            end else begin
              state_q <= S_WC;
              cnt_q   <= ewp_cnt_t'(WC_CYC - 1);
            end
          end
          S_RD:    state_q <= S_IDLE;
          S_WC:    state_q <= S_IDLE;
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_q      <= '0;
      pins_q.ce_n <= 1'b1;
      pins_q.oe_n <= 1'b1;
      pins_q.we_n <= 1'b1;
      pins_q.write_guard_n <= 1'b0;
    end else if (en_in) begin
      // guard rises once out of reset and stays high for all access
      pins_q.write_guard_n <= 1'b1;
      if (take) begin
        pins_q.addr <= cmd_in.addr;
        if (cmd_in.op == OP_READ) begin
          pins_q.dq_oe <= 1'b0;
          pins_q.ce_n  <= 1'b0;
          pins_q.oe_n  <= 1'b0;
        end else begin
          pins_q.addr  <= first_w[ADDR_W+DATA_W-1:DATA_W];
          pins_q.dq    <= first_w[DATA_W-1:0];
          pins_q.dq_oe <= 1'b1;
        end
      end else if (tick) begin
        unique case (state_q)
          S_SETUP: begin
            pins_q.ce_n <= 1'b0;
            pins_q.we_n <= 1'b0;
          end
          S_STB: begin
            pins_q.ce_n <= 1'b1;
            pins_q.we_n <= 1'b1;
          end
          S_HOLD: begin
            if (more) begin
              pins_q.addr <= next_w[ADDR_W+DATA_W-1:DATA_W];
              pins_q.dq   <= next_w[DATA_W-1:0];
            end else begin
              pins_q.dq_oe <= 1'b0;
            end
          end
          S_RD: begin
            pins_q.ce_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
          end
          default: pins_q.dq_oe <= pins_q.dq_oe;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection state and read result
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prot_q <= 1'b0;
      rd_q   <= '0;
      rdv_q  <= 1'b0;
    end else if (en_in) begin
      rdv_q <= 1'b0;
      if (tick && state_q == S_HOLD && !more) begin
        if (cmd_q.op == OP_UNPROT) begin
          prot_q <= 1'b0;
        end else if (pre_q) begin
          prot_q <= 1'b1;
        end
      end
      if (tick && state_q == S_RD) begin
        rd_q  <= dq_s2_q;
        rdv_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ewp_cnt_t wlen_q;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wlen_q <= '0;
    end else if (en_in) begin
      wlen_q <= pins_q.we_n ? '0 : wlen_q + ewp_cnt_t'(1);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in || !en_in);

  sequence strobe_end;
    $rose(pins_q.we_n);
  endsequence
  sequence next_strobe;
    ##[1:8] $fell(pins_q.we_n);
  endsequence

  a_guard_access: assert property (!pins_q.ce_n |-> pins_q.write_guard_n)
    else $error("guard low during access");
  a_strobe_width: assert property (strobe_end |->
      wlen_q >= ewp_cnt_t'(STB_CYC) &&
      wlen_q > ewp_cnt_t'(GLITCH_CYC))
    else $error("write strobe too short");
  a_wc_guard: assert property (state_q == S_WC |-> pins_q.write_guard_n)
    else $error("guard dropped in write cycle");
  a_wc_hold: assert property ((state_q == S_WC && !tick) |=>
      state_q == S_WC && pins_q.we_n && pins_q.ce_n)
    else $error("write cycle cut short");
  a_byte_gap: assert property ((strobe_end and (state_q == S_HOLD && more))
      |-> next_strobe)
    else $error("next byte late");
  a_pins_steady: assert property ((!pins_q.we_n && !$past(pins_q.we_n)) |->
      $stable(pins_q.addr) && $stable(pins_q.dq) && pins_q.dq_oe)
    else $error("address or data moved under strobe");
  a_prefix_head: assert property (($fell(pins_q.we_n) && step_q == '0 &&
      pre_q && cmd_q.op != OP_UNPROT) |->
      pins_q.addr == CMD_ADDR_A && pins_q.dq == CMD_AA)
    else $error("bad prefix head");
  a_cancel_tail: assert property (($fell(pins_q.we_n) &&
      cmd_q.op == OP_UNPROT && step_q == CANCEL_LEN - 3'h1) |->
      pins_q.addr == CMD_ADDR_A && pins_q.dq == CMD_20)
    else $error("bad cancel tail");
  a_prot_write: assert property (($fell(pins_q.we_n) && prot_q &&
      cmd_q.op != OP_UNPROT) |-> pre_q)
    else $error("protected write without prefix");
  a_read_nodrive: assert property (!pins_q.oe_n |->
      !pins_q.dq_oe && pins_q.we_n)
    else $error("bus contention on read");

endmodule : ewp_host
`default_nettype wire

// *** tb/ewp_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ewp_dev_model
  import ewp_pkg::*;
#(
  parameter int BUSY_NS = 40
) (
  // pins as seen at the device
  input  wire ewp_pins_t pins_in,
  // device drive and mode
  output ewp_data_t      dq_out,
  output logic           dq_oe_out,
  output logic           prot_out
);
  ewp_data_t mem [ewp_addr_t];
  ewp_addr_t sa [6];
  ewp_data_t sd [6];
  ewp_addr_t lat_a;
  ewp_addr_t pend_a;
  ewp_data_t pend_d;
  ewp_data_t last_d;
  logic      wr;
  logic      busy;
  logic      unlock;
  int        step;
  time       t_fall;

  ////////////////////////////////////////
  initial begin
    sa = '{CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A,
           CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A};
    sd = '{CMD_AA, CMD_55, CMD_80, CMD_AA, CMD_55, CMD_20};
    busy = 1'b0;
    unlock = 1'b0;
    step = 0;
    t_fall = 0;
    prot_out = 1'b0;
    last_d = 8'h00;
  end

  assign wr = !pins_in.ce_n && !pins_in.we_n && pins_in.oe_n
              && pins_in.write_guard_n;

  task automatic accept(input ewp_addr_t a, input ewp_data_t d);
    if (step == 2 && a == CMD_ADDR_A && d == CMD_A0) begin
      prot_out = 1'b1;
      unlock = 1'b1;
      step = 0;
    end else if (a == sa[step] && d == sd[step]) begin
      step = (step == 5) ? 0 : step + 1;
      if (step == 0) prot_out = 1'b0;
    end else begin
      step = 0;
      if (!prot_out || unlock) begin
        pend_a = a;
        pend_d = d;
        busy = 1'b1;
        unlock = 1'b0;
      end
    end
  endtask : accept

  // address on the falling strobe, data on the rising one
  always @(wr) begin
    if (wr === 1'b1) begin
      t_fall = $time;
      lat_a = pins_in.addr;
    end else if (pins_in.write_guard_n === 1'b1
                 && $time - t_fall > GLITCH_NS) begin
      accept(lat_a, pins_in.dq);
    end
  end

  // short fixed busy time stands in for the idle-start page timer
  always @(posedge busy) begin
    #(BUSY_NS);
    if (busy) mem[pend_a] = pend_d;
    busy = 1'b0;
  end

  always @(negedge pins_in.write_guard_n) busy = 1'b0;

  // released bus shows the inverse so a stale value never passes
  always @(pins_in or busy) begin
    dq_oe_out = !pins_in.ce_n && !pins_in.oe_n && pins_in.write_guard_n;
    if (dq_oe_out) begin
      last_d = mem.exists(pins_in.addr) ? mem[pins_in.addr] : 8'hff;
      if (busy) last_d[7] = ~pend_d[7];
    end
    dq_out = dq_oe_out ? last_d : ~last_d;
  end
endmodule : ewp_dev_model
`default_nettype wire

// *** tb/ewp_write_protection_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module ewp_write_protection_tb;
  import ewp_pkg::*;
  typedef struct {
    ewp_op_t op; ewp_addr_t a; ewp_data_t d; logic p;
  } ewp_row_t;
  logic      core_clk, rst, en, cmd_valid, ready, rd_valid, prot, dev_prot;
  logic      ovr, dev_oe;
  ewp_cmd_t  cmd;
  ewp_data_t rd_data, dq_in, dev_dq, rd_seen;
  ewp_pins_t pins, ovr_pins, m_pins;
  int        failures, comparisons;
  ewp_row_t  rows [12] = '{
    '{OP_WRITE, 17'h00010, 8'h3c, 1'b0}, '{OP_READ, 17'h00010, 8'h3c, 1'b0},
    '{OP_WR_PROT, 17'h00020, 8'h5a, 1'b1}, '{OP_READ, 17'h00020, 8'h5a, 1'b1},
    '{OP_WRITE, 17'h00030, 8'hc3, 1'b1}, '{OP_READ, 17'h00030, 8'hc3, 1'b1},
    '{OP_UNPROT, 17'h00000, 8'h00, 1'b0}, '{OP_READ, 17'h05555, 8'hff, 1'b0},
    '{OP_READ, 17'h02aaa, 8'hff, 1'b0}, '{OP_WRITE, 17'h05555, 8'haa, 1'b0},
    '{OP_WRITE, 17'h00060, 8'h11, 1'b0}, '{OP_READ, 17'h00060, 8'h11, 1'b0}};

  ////////////////////////////////////////
  assign m_pins = ovr ? ovr_pins : pins;
  assign dq_in = pins.dq_oe ? pins.dq : dev_dq;

  ewp_host #(.WC_CYC(20), .RP_CYC(4)) i_dut (
    .core_clk_in   (core_clk),
    .rst_in        (rst),
    .en_in         (en),
    .cmd_valid_in  (cmd_valid),
    .cmd_in        (cmd),
    .cmd_ready_out (ready),
    .rd_data_out   (rd_data),
    .rd_valid_out  (rd_valid),
    .prot_out      (prot),
    .dq_in         (dq_in),
    .pins_out      (pins)
  );
  ewp_dev_model i_dev (
    .pins_in   (m_pins),
    .dq_out    (dev_dq),
    .dq_oe_out (dev_oe),
    .prot_out  (dev_prot)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic do_cmd(input ewp_op_t op, input ewp_addr_t a,
                        input ewp_data_t d);
    int n;
    cmd = '{op, a, d};
    cmd_valid = 1'b1;
    rd_seen = 8'hxx;
    for (n = 0; n < 2000 && ready !== 1'b1; n++) tick(1);
    if (n >= 2000) begin
      failures++;
      finish_test();
    end
    tick(1);
    cmd_valid = 1'b0;
    for (n = 0; n < 2000; n++) begin
      if (rd_valid === 1'b1) rd_seen = rd_data;
      if (ready === 1'b1) break;
      tick(1);
    end
    if (n >= 2000) begin
      failures++;
      finish_test();
    end
  endtask : do_cmd

  // raw strobe of w ns driven past the host; g is the guard level
  task automatic ovr_wr(input ewp_addr_t a, input ewp_data_t d, input int w,
                        input logic g, input logic drop);
    ovr_pins = pins;
    ovr_pins.addr = a;
    ovr_pins.dq = d;
    ovr_pins.write_guard_n = g;
    ovr = 1'b1;
    tick(2);
    ovr_pins.ce_n = 1'b0;
    ovr_pins.we_n = 1'b0;
    #(w);
    ovr_pins.ce_n = 1'b1;
    ovr_pins.we_n = 1'b1;
    if (!drop && g && w > GLITCH_NS) begin
      // poll inside the busy window: bit 7 comes back inverted
      #2 ovr_pins.ce_n = 1'b0;
      ovr_pins.oe_n = 1'b0;
      #2 check({7'h00, dev_dq[7]}, {7'h00, ~d[7]});
      ovr_pins.ce_n = 1'b1;
      ovr_pins.oe_n = 1'b1;
    end
    if (drop) #4 ovr_pins.write_guard_n = 1'b0;
    tick(20);
    ovr = 1'b0;
    tick(2);
  endtask : ovr_wr

  // guard must stay high whenever the host selects the device
  always @(negedge core_clk) begin
    if (!rst && pins.ce_n === 1'b0) check(pins.write_guard_n, 1'b1);
    if (!rst && dev_oe === 1'b1) check(pins.dq_oe, 1'b0);
  end

  ////////////////////////////////////////
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    ovr = 1'b0;
    ovr_pins = '0;
    tick(16);
    check(pins.write_guard_n, 1'b0);
    check({pins.ce_n, pins.we_n, ready}, 8'h06);
    rst = 1'b0;
    foreach (rows[i]) begin
      do_cmd(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == OP_READ) check(rd_seen, rows[i].d);
      check(prot, rows[i].p);
      check(dev_prot, rows[i].p);
    end
    ovr_wr(17'h00050, 8'h77, 20, 1'b1, 1'b0);
    ovr_wr(17'h00051, 8'hb8, 24, 1'b1, 1'b0);
    ovr_wr(17'h00052, 8'h79, 40, 1'b1, 1'b1);
    ovr_wr(17'h00053, 8'h7a, 40, 1'b0, 1'b0);
    do_cmd(OP_READ, 17'h00050, 8'h00);
    check(rd_seen, 8'hff);
    do_cmd(OP_READ, 17'h00051, 8'h00);
    check(rd_seen, 8'hb8);
    do_cmd(OP_READ, 17'h00052, 8'h00);
    check(rd_seen, 8'hff);
    do_cmd(OP_READ, 17'h00053, 8'h00);
    check(rd_seen, 8'hff);
    finish_test();
  end
endmodule : ewp_write_protection_tb
`default_nettype wire
